// file: src/dpc_defs.svh
// Constants for the dual-port memory port controller: offsets, fields and timing counts.
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ----------------------------------------------------------------------------
`define DPC_REG_CFG 4'h0
`define DPC_REG_CMD 4'h4
`define DPC_REG_STATUS 4'h8

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DPC_CFG_SIDE 0
`define DPC_CFG_DRIVE 1
`define DPC_CFG_INHIBIT 2
`define DPC_CMD_ADDR_LSB 0
`define DPC_CMD_ADDR_MSB 12
`define DPC_CMD_DATA_LSB 16
`define DPC_CMD_DATA_MSB 23
`define DPC_CMD_WRITE 24
`define DPC_CMD_SEM 25
`define DPC_ST_ACTIVE 0
`define DPC_ST_CONFLICT 1
`define DPC_ST_MAILBOX 2
`define DPC_ST_INIT 3
`define DPC_ST_DATA_LSB 8
`define DPC_ST_DATA_MSB 15

// ----------------------------------------------------------------------------
// Reset values and fixed addresses
// ----------------------------------------------------------------------------
`define DPC_CFG_RESET 3'h0
`define DPC_MAILBOX_LEFT 13'h1ffe
`define DPC_MAILBOX_RIGHT 13'h1fff
`define DPC_PIN_SYNC_W 10

// ----------------------------------------------------------------------------
// Timing: figures in ns, counts in mclk cycles rounded up, at least one
// ----------------------------------------------------------------------------
`define DPC_CLK_MHZ 20
`define DPC_T_WP_NS 25
`define DPC_T_WH_NS 25
`define DPC_T_AA_NS 35
`define DPC_SYNC_CYC 2
`define DPC_CYC_UP(ns) (((((ns) * `DPC_CLK_MHZ) + 999) / 1000) < 1 ? 1 : \
   ((((ns) * `DPC_CLK_MHZ) + 999) / 1000))
`define DPC_WP_CYC (`DPC_CYC_UP(`DPC_T_WP_NS))
`define DPC_WH_CYC (`DPC_CYC_UP(`DPC_T_WH_NS))
`define DPC_RD_CYC (`DPC_CYC_UP(`DPC_T_AA_NS) + `DPC_SYNC_CYC)

`endif

// file: src/dpc_pkg.sv
// Types shared by the dual-port memory port controller.
package dpc_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} dpc_state_t;
endpackage

// file: src/dpc_pin_sync.sv
// Two-flop synchroniser bank for the asynchronous memory pins.
`timescale 1ns/1ps
`include "dpc_defs.svh"
module dpc_pin_sync (
   input wire logic mclk, // System clock.
   input wire logic rstN, // Synchronised reset, active low.
   input wire logic [`DPC_PIN_SYNC_W-1:0] din, // Asynchronous pin levels.
   output logic [`DPC_PIN_SYNC_W-1:0] dout // Levels safe to read on mclk.
);
   logic [`DPC_PIN_SYNC_W-1:0] meta;

   // Pins idle high, so the chain resets to ones and shows no false event.
   genvar i;
   generate
      for (i = 0; i < `DPC_PIN_SYNC_W; i = i + 1) begin : g_bit
         always_ff @(posedge mclk or negedge rstN) begin
            if (!rstN) begin
               meta[i] <= 1'b1;
               dout[i] <= 1'b1;
            end else begin
               meta[i] <= din[i];
               dout[i] <= meta[i];
            end
         end
      end
   endgenerate
endmodule

// file: src/dpc_port_controller.sv
// Controller driving one port of the dual-port memory, ordered over Avalon-MM.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "dpc_defs.svh"

module dpc_port_controller (
   input wire logic mclk, // 20 MHz clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic [3:0] avsAddress, // Avalon byte address.
   input wire logic avsRead, // Avalon read request.
   input wire logic avsWrite, // Avalon write request.
   input wire logic [31:0] avsWritedata, // Avalon write data.
   output logic [31:0] avsReaddata, // Avalon read data.
   output logic avsWaitrequest, // Avalon wait, low for the accepting cycle.
   output logic [12:0] ramAddress, // Port address to the memory.
   output logic ramCeN, // Memory chip enable, active low.
   output logic flagSpaceSelectN, // Semaphore space select, active low.
   output logic ramOeN, // Output enable, active low.
   output logic ramRwN, // Write strobe, active low.
   input wire logic [7:0] dataIn, // Data pins as seen.
   output logic [7:0] dataOut, // Data we drive.
   output logic dataOeN, // Data drive enable, active low.
   input wire logic conflictIn, // Busy pin level, low means busy.
   output logic conflictOutN, // Busy pin level we drive, low inhibits.
   output logic conflictOeN, // Busy pin drive enable, active low.
   input wire logic mailboxIrqN // Our side's mailbox flag, active low.
);
   import dpc_pkg::*;

   // -------------------------------------------------------------------------
   // Reset release and pin synchronisers
   // -------------------------------------------------------------------------
   logic rstMeta;
   logic rstN;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN <= rstMeta;
      end
   end

   logic [`DPC_PIN_SYNC_W-1:0] pinSync;
   logic [7:0] dataSync;
   logic conflictSync;
   logic irqSync;
   dpc_pin_sync u_sync (
      .mclk(mclk),
      .rstN(rstN),
      .din({mailboxIrqN, conflictIn, dataIn}),
      .dout(pinSync)
   );
   assign dataSync = pinSync[7:0];
   assign conflictSync = pinSync[8];
   assign irqSync = pinSync[9];

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   dpc_state_t state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [2:0] cfg, next_cfg;
   logic opWrite, next_opWrite;
   logic opSem, next_opSem;
   logic [12:0] opAddr, next_opAddr;
   logic [7:0] opData, next_opData;
   logic [7:0] rdByte, next_rdByte;
   logic conflictSeen, next_conflictSeen;
   logic initDone, next_initDone;
   logic [31:0] next_avsReaddata;
   logic next_avsWaitrequest;
   logic [12:0] next_ramAddress;
   logic next_ramCeN, next_flagSpaceSelectN, next_ramOeN, next_ramRwN;
   logic [7:0] next_dataOut;
   logic next_dataOeN, next_conflictOutN, next_conflictOeN;
   logic busyNow;
   logic accept;
   logic cmdGo;
   logic capture;
   logic active;

   // While we drive the busy pin ourselves its level is our own, not a stall.
   assign busyNow = !conflictSync && conflictOeN;

   function automatic logic [12:0] own_mailbox(input logic side);
      own_mailbox = side ? `DPC_MAILBOX_RIGHT : `DPC_MAILBOX_LEFT;
   endfunction

   // -------------------------------------------------------------------------
   // Avalon slave and access sequencer
   // -------------------------------------------------------------------------
   always_comb begin
      next_cfg = cfg;
      next_avsWaitrequest = 1'b1;
      next_avsReaddata = avsReaddata;
      cmdGo = 1'b0;
      // Command writes stall until the port is idle and the startup read is done.
      accept = (avsRead || avsWrite) && avsWaitrequest && !(avsWrite
         && avsAddress == `DPC_REG_CMD && (state != ST_IDLE || !initDone));
      if (accept) begin
         next_avsWaitrequest = 1'b0;
         next_avsReaddata = 32'h0;
         if (avsWrite) begin
            if (avsAddress == `DPC_REG_CFG) begin
               next_cfg = avsWritedata[2:0];
            end else if (avsAddress == `DPC_REG_CMD) begin
               cmdGo = 1'b1;
            end
         end else begin
            case (avsAddress)
               `DPC_REG_CFG: next_avsReaddata = {29'h0, cfg};
               `DPC_REG_CMD: next_avsReaddata = {6'h0, opSem, opWrite, opData, 3'h0, opAddr};
               `DPC_REG_STATUS: begin
                  next_avsReaddata[`DPC_ST_ACTIVE] = (state != ST_IDLE);
                  next_avsReaddata[`DPC_ST_CONFLICT] = conflictSeen;
                  next_avsReaddata[`DPC_ST_MAILBOX] = !irqSync;
                  next_avsReaddata[`DPC_ST_INIT] = initDone;
                  next_avsReaddata[`DPC_ST_DATA_MSB:`DPC_ST_DATA_LSB] = rdByte;
               end
               default: next_avsReaddata = 32'h0;
            endcase
         end
      end
   end

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_opWrite = opWrite;
      next_opSem = opSem;
      next_opAddr = opAddr;
      next_opData = opData;
      next_rdByte = rdByte;
      next_conflictSeen = conflictSeen;
      next_initDone = initDone;
      capture = 1'b0;
      case (state)
         ST_IDLE: begin
            if (!initDone) begin
               // A read of our own mailbox leaves its flag cleared.
               next_opWrite = 1'b0;
               next_opSem = 1'b0;
               next_opAddr = own_mailbox(cfg[`DPC_CFG_SIDE]);
               next_conflictSeen = 1'b0;
               next_state = ST_SETUP;
            end else if (cmdGo) begin
               next_opWrite = avsWritedata[`DPC_CMD_WRITE];
               next_opSem = avsWritedata[`DPC_CMD_SEM];
               next_opAddr = avsWritedata[`DPC_CMD_ADDR_MSB:`DPC_CMD_ADDR_LSB];
               next_opData = avsWritedata[`DPC_CMD_DATA_MSB:`DPC_CMD_DATA_LSB];
               next_conflictSeen = 1'b0;
               next_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            next_cnt = opWrite ? 4'(`DPC_WP_CYC) : 4'(`DPC_RD_CYC);
            next_state = ST_STROBE;
         end
         ST_STROBE: begin
            if (busyNow) begin
               // Stall while busy and restart the wait so the strobe outlasts it.
               next_conflictSeen = 1'b1;
               next_cnt = opWrite ? 4'(`DPC_WH_CYC) : 4'(`DPC_RD_CYC);
            end else if (cnt != 4'h0) begin
               next_cnt = cnt - 4'h1;
            end else begin
               if (!opWrite) begin
                  capture = 1'b1;
                  next_rdByte = dataSync;
               end
               next_initDone = 1'b1;
               next_state = ST_RECOVER;
            end
         end
         ST_RECOVER: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase

      // Pins follow the next state so every output is a plain flip-flop.
      active = (next_state == ST_SETUP) || (next_state == ST_STROBE);
      next_ramAddress = next_opAddr;
      next_ramCeN = !(active && !next_opSem);
      next_flagSpaceSelectN = !(active && next_opSem);
      next_ramOeN = !(active && !next_opWrite);
      next_ramRwN = !((next_state == ST_STROBE) && next_opWrite);
      // Write data stays driven one cycle after the strobe rises for hold time.
      next_dataOeN = !((active || next_state == ST_RECOVER) && next_opWrite);
      next_dataOut = next_opData;
      // The inhibit level moves only while idle, one cycle ahead of any strobe.
      next_conflictOutN = conflictOutN;
      next_conflictOeN = conflictOeN;
      if (state == ST_IDLE) begin
         next_conflictOutN = !cfg[`DPC_CFG_INHIBIT];
         next_conflictOeN = !cfg[`DPC_CFG_DRIVE];
      end
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         cfg <= `DPC_CFG_RESET;
         opWrite <= 1'b0;
         opSem <= 1'b0;
         opAddr <= 13'h0;
         opData <= 8'h0;
         rdByte <= 8'h0;
         conflictSeen <= 1'b0;
         initDone <= 1'b0;
         avsReaddata <= 32'h0;
         avsWaitrequest <= 1'b1;
         ramAddress <= 13'h0;
         ramCeN <= 1'b1;
         flagSpaceSelectN <= 1'b1;
         ramOeN <= 1'b1;
         ramRwN <= 1'b1;
         dataOut <= 8'h0;
         dataOeN <= 1'b1;
         conflictOutN <= 1'b1;
         conflictOeN <= 1'b1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         cfg <= next_cfg;
         opWrite <= next_opWrite;
         opSem <= next_opSem;
         opAddr <= next_opAddr;
         opData <= next_opData;
         rdByte <= next_rdByte;
         conflictSeen <= next_conflictSeen;
         initDone <= next_initDone;
         avsReaddata <= next_avsReaddata;
         avsWaitrequest <= next_avsWaitrequest;
         ramAddress <= next_ramAddress;
         ramCeN <= next_ramCeN;
         flagSpaceSelectN <= next_flagSpaceSelectN;
         ramOeN <= next_ramOeN;
         ramRwN <= next_ramRwN;
         dataOut <= next_dataOut;
         dataOeN <= next_dataOeN;
         conflictOutN <= next_conflictOutN;
         conflictOeN <= next_conflictOeN;
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   logic [5:0] sinceReset;
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         sinceReset <= 6'h0;
      end else if (sinceReset != 6'h3f) begin
         sinceReset <= sinceReset + 6'h1;
      end
   end

   chk_init_mailbox: assert property (@(posedge mclk) disable iff (!rstN)
      (state == ST_STROBE && !initDone) |-> (ramAddress == own_mailbox(cfg[`DPC_CFG_SIDE])
      && !ramOeN && ramRwN && !ramCeN))
      else $error("startup access is not a read of our own mailbox");

   chk_init_bound: assert property (@(posedge mclk) disable iff (!rstN)
      (sinceReset == 6'h3f && !conflictSeen) |-> initDone)
      else $error("startup mailbox read did not finish in time");

   chk_space_select: assert property (@(posedge mclk) disable iff (!rstN)
      !flagSpaceSelectN |-> ramCeN)
      else $error("flag space selected with memory enable low");

   chk_inhibit_ahead: assert property (@(posedge mclk) disable iff (!rstN)
      $fell(ramRwN) |-> ($stable(conflictOutN) && $stable(conflictOeN)
      && $past(state) == ST_SETUP))
      else $error("busy drive changed as a write strobe began");

   chk_hold_after_busy: assert property (@(posedge mclk) disable iff (!rstN)
      ($rose(conflictSync) && conflictOeN && !ramRwN) |-> ##1 !ramRwN)
      else $error("write strobe released too soon after busy ended");

   chk_stall_read: assert property (@(posedge mclk) disable iff (!rstN)
      capture |-> (!busyNow && !$past(busyNow)))
      else $error("read data taken while busy");
endmodule

// file: tb/dpc_ram_model.sv
// Behavioural dual-port memory with mailbox flags, busy arbitration and semaphores.
`timescale 1ns/1ps
module dpc_ram_model (
   input wire logic mclk, // Sampling clock.
   input wire logic rstN, // Reset, active low.
   input wire logic ms, // High master, low slave.
   input wire logic [12:0] lAddr, // Left address.
   input wire logic lCeN, // Left enable.
   input wire logic lSemN, // Left flag select.
   input wire logic lOeN, // Left output enable.
   input wire logic lRwN, // Left strobe.
   input wire logic [7:0] lDin, // Left data pins.
   input wire logic lBusyPin, // Left busy pin level.
   output logic [7:0] lDout, // Left read data.
   output logic lDrv, // Left data driven.
   output logic lBusyN, // Left busy drive.
   output logic lIrqN, // Left mailbox flag.
   input wire logic [12:0] rAddr, // Right address.
   input wire logic rCeN, // Right enable.
   input wire logic rSemN, // Right flag select.
   input wire logic rOeN, // Right output enable.
   input wire logic rRwN, // Right strobe.
   input wire logic [7:0] rDin, // Right data.
   output logic [7:0] rDout, // Right read data.
   output logic rIrqN // Right mailbox flag.
);
   logic [7:0] mem [0:8191];
   logic [1:0] own [0:7];
   logic [1:0] req [0:7];
   logic [21:0] lCap, rCap;
   logic lPend, rPend, wonL, wonR, lEnQ, rEnQ, match, lBusy, tieL, inhL, inhR;
   logic [12:0] lAddrQ, rAddrQ;
   assign match = !lCeN && !rCeN && lAddr == rAddr;
   assign tieL = !(lEnQ && lAddrQ == lAddr && !(rEnQ && rAddrQ == rAddr));
   // Right busy is set only on a match where left busy is not, so both can never be low.
   assign lBusy = match && (wonR || !wonL && tieL);
   assign lBusyN = ms ? !lBusy : 1'b1;
   assign inhL = ms ? lBusy : !lBusyPin;
   assign inhR = ms ? match && !lBusy : 1'b0;
   assign lDrv = !lOeN && lRwN && (lCeN != lSemN);
   assign lDout = !lSemN ? {8{own[lAddr[2:0]] != 2'd1}} : mem[lAddr];
   assign rDout = !rSemN ? {8{own[rAddr[2:0]] != 2'd2}} : mem[rAddr];
   task automatic put(input logic rt, input logic [21:0] c);
      logic [2:0] i;
      logic [1:0] me;
      i = c[10:8];
      me = rt ? 2'd2 : 2'd1;
      if (!c[21]) begin
         mem[c[20:8]] <= c[7:0];
         if (!rt && c[20:8] == 13'h1fff) rIrqN <= 1'b0;
         if (rt && c[20:8] == 13'h1ffe) lIrqN <= 1'b0;
      end else if (!c[0]) begin
         if (own[i] == 2'd0) own[i] <= me;
         else if (own[i] != me) req[i][rt] <= 1'b1;
      end else begin
         req[i][rt] <= 1'b0;
         if (own[i] == me) own[i] <= req[i][!rt] ? 2'd3 - me : 2'd0;
         if (own[i] == me) req[i][!rt] <= 1'b0;
      end
   endtask
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         for (int k = 0; k < 8192; k++) mem[k] <= 8'h00;
         for (int k = 0; k < 8; k++) own[k] <= 2'd0;
         for (int k = 0; k < 8; k++) req[k] <= 2'b00;
         // Left flag starts set, as power-up leaves it undefined.
         lIrqN <= 1'b0;
         rIrqN <= 1'b1;
         {lPend, rPend, wonL, wonR, lEnQ, rEnQ} <= 6'h00;
      end else begin
         // A write counts only if busy is gone by the end of the strobe.
         if (!lRwN && lCeN != lSemN) lCap <= {!lSemN, lAddr, lDin};
         if (!lRwN && lCeN != lSemN) lPend <= !inhL;
         else if (lPend) put(1'b0, lCap);
         if (!(!lRwN && lCeN != lSemN) && lPend) lPend <= 1'b0;
         if (!rRwN && rCeN != rSemN) rCap <= {!rSemN, rAddr, rDin};
         if (!rRwN && rCeN != rSemN) rPend <= !inhR;
         else if (rPend) put(1'b1, rCap);
         if (!(!rRwN && rCeN != rSemN) && rPend) rPend <= 1'b0;
         if (!rCeN && !rOeN && rAddr == 13'h1fff) rIrqN <= 1'b1;
         if (!lCeN && !lOeN && lAddr == 13'h1ffe) lIrqN <= 1'b1;
         wonL <= match && !lBusy;
         wonR <= lBusy;
         lEnQ <= !lCeN;
         rEnQ <= !rCeN;
         lAddrQ <= lAddr;
         rAddrQ <= rAddr;
      end
   end
endmodule

// file: tb/tb.sv
// Self-checking bench for the port controller against the memory model.
`timescale 1ns/1ps
module tb;
   logic mclk, reset_n, avsRead, avsWrite, avsWaitrequest, ms;
   logic [3:0] avsAddress;
   logic [31:0] avsWritedata, avsReaddata, st;
   logic [12:0] ramAddress, rAddr;
   logic ramCeN, flagSpaceSelectN, ramOeN, ramRwN, dataOeN, conflictOutN, conflictOeN;
   logic conflictIn, mailboxIrqN, lDrv, lBusyN, rIrqN, rCeN, rSemN, rOeN, rRwN;
   logic [7:0] dataIn, dataOut, lDout, rDout, rDin, b;
   int checks, miscompares;
   // A released data bus shows a pattern that changes at every clock edge, twice a cycle.
   assign dataIn = !dataOeN ? dataOut : lDrv ? lDout : 8'h5a ^ {8{mclk}};
   assign conflictIn = !conflictOeN ? conflictOutN : lBusyN;
   dpc_port_controller uut (.mclk(mclk), .reset_n(reset_n), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
      .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .ramAddress(ramAddress),
      .ramCeN(ramCeN), .flagSpaceSelectN(flagSpaceSelectN), .ramOeN(ramOeN),
      .ramRwN(ramRwN), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
      .conflictIn(conflictIn), .conflictOutN(conflictOutN), .conflictOeN(conflictOeN),
      .mailboxIrqN(mailboxIrqN));
   dpc_ram_model ram (.mclk(mclk), .rstN(reset_n), .ms(ms), .lAddr(ramAddress),
      .lCeN(ramCeN), .lSemN(flagSpaceSelectN), .lOeN(ramOeN), .lRwN(ramRwN),
      .lDin(dataIn), .lBusyPin(conflictIn), .lDout(lDout), .lDrv(lDrv), .lBusyN(lBusyN),
      .lIrqN(mailboxIrqN), .rAddr(rAddr), .rCeN(rCeN), .rSemN(rSemN), .rOeN(rOeN),
      .rRwN(rRwN), .rDin(rDin), .rDout(rDout), .rIrqN(rIrqN));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // The request is held until an edge samples waitrequest low.
   task automatic avAcc(input logic [3:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
      avsAddress <= a;
      avsWritedata <= d;
      {avsRead, avsWrite} <= {!w, w};
      do begin
         @(posedge mclk);
      end while (avsWaitrequest !== 1'b0);
      q = avsReaddata;
      {avsRead, avsWrite} <= 2'b00;
      @(posedge mclk);
   endtask
   task automatic op(input logic [12:0] a, input logic [7:0] d, input logic w,
      input logic s, output logic [31:0] q);
      avAcc(4'h4, 1'b1, {6'h0, s, w, d, 3'h0, a}, q);
      do begin
         avAcc(4'h8, 1'b0, 32'h0, q);
      end while (q[0] !== 1'b0);
   endtask
   task automatic rAcc(input logic [12:0] a, input logic w, input logic [7:0] d,
      input logic s, output logic [7:0] q);
      rAddr <= a;
      rDin <= d;
      {rCeN, rSemN, rOeN, rRwN} <= {s, !s, w, !w};
      repeat (3) @(posedge mclk);
      q = rDout;
      {rCeN, rSemN, rOeN, rRwN} <= 4'hf;
      // Leave time for a flag change to cross the controller's synchroniser.
      repeat (4) @(posedge mclk);
   endtask
   initial begin
      #3000000;
      miscompares++;
      wrap_up();
   end
   // ------------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------------
   initial begin
      {reset_n, avsRead, avsWrite, avsAddress, avsWritedata} = '0;
      {ms, rCeN, rSemN, rOeN, rRwN, rAddr, rDin} = {5'h1f, 21'h0};
      checks = 0;
      miscompares = 0;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      do begin
         avAcc(4'h8, 1'b0, 32'h0, st);
      end while (st[3] !== 1'b1);
      chk({30'h0, st[3:2]}, 32'h2);
      avAcc(4'hc, 1'b1, 32'hffffffff, st);
      avAcc(4'hc, 1'b0, 32'h0, st);
      chk(st, 32'h0);
      $display("test init done");
      rAcc(13'h1ffe, 1'b1, 8'h3c, 1'b0, b);
      avAcc(4'h8, 1'b0, 32'h0, st);
      chk({31'h0, st[2]}, 32'h1);
      op(13'h1ffe, 8'h00, 1'b0, 1'b0, st);
      chk({24'h0, st[15:8]}, 32'h3c);
      avAcc(4'h8, 1'b0, 32'h0, st);
      chk({31'h0, st[2]}, 32'h0);
      op(13'h1fff, 8'h5a, 1'b1, 1'b0, st);
      chk({31'h0, rIrqN}, 32'h0);
      rAcc(13'h1fff, 1'b0, 8'h00, 1'b0, b);
      chk({24'h0, b}, 32'h5a);
      chk({31'h0, rIrqN}, 32'h1);
      $display("test mailbox done");
      for (int i = 0; i < 8; i++) begin
         op(i[12:0], 8'hfe, 1'b1, 1'b1, st);
         op(i[12:0], 8'h00, 1'b0, 1'b1, st);
         chk({24'h0, st[15:8]}, 32'h00);
         rAcc(i[12:0], 1'b0, 8'h00, 1'b1, b);
         chk({24'h0, b}, 32'hff);
         rAcc(i[12:0], 1'b1, 8'hfe, 1'b1, b);
         op(i[12:0], 8'h00, 1'b0, 1'b1, st);
         chk({24'h0, st[15:8]}, 32'h00);
         op(i[12:0], 8'h01, 1'b1, 1'b1, st);
         rAcc(i[12:0], 1'b0, 8'h00, 1'b1, b);
         chk({24'h0, b}, 32'h00);
         rAcc(i[12:0], 1'b1, 8'h01, 1'b1, b);
         op(i[12:0], 8'h00, 1'b0, 1'b1, st);
         chk({24'h0, st[15:8]}, 32'hff);
      end
      avAcc(4'h4, 1'b0, 32'h0, st);
      chk(st, 32'h02000007);
      $display("test semaphore done");
      rAddr <= 13'h0050;
      {rCeN, rOeN} <= 2'b00;
      fork
         op(13'h0050, 8'h77, 1'b1, 1'b0, st);
         begin
            repeat (40) @(posedge mclk);
            {rCeN, rOeN} <= 2'b11;
         end
      join
      chk({31'h0, st[1]}, 32'h1);
      op(13'h0050, 8'h00, 1'b0, 1'b0, st);
      chk({24'h0, st[15:8]}, 32'h77);
      $display("test busy done");
      ms <= 1'b0;
      op(13'h0060, 8'h22, 1'b1, 1'b0, st);
      avAcc(4'h0, 1'b1, 32'h6, st);
      avAcc(4'h0, 1'b0, 32'h0, st);
      chk(st, 32'h6);
      op(13'h0060, 8'h11, 1'b1, 1'b0, st);
      avAcc(4'h0, 1'b1, 32'h0, st);
      op(13'h0060, 8'h00, 1'b0, 1'b0, st);
      chk({24'h0, st[15:8]}, 32'h22);
      ms <= 1'b1;
      $display("test slave done");
      wrap_up();
   end
endmodule
